//--- code_5b.v
// 4B/5B data code-group encoder and decoder
`timescale 1ns/1ps
module code_5b (
  // Encode side
  input  wire [3:0] nib_i,
  output wire [4:0] sym_o,
  // Decode side
  input  wire [4:0] grp_i,
  output reg  [3:0] nib_o,
  output wire       data_o
);

  wire [15:0] hit;

  // Fixed data mapping
  function [4:0] enc;
    input [3:0] n;
    begin
      case (n)
        4'h0: enc = 5'h1e;
        4'h1: enc = 5'h09;
        4'h2: enc = 5'h14;
        4'h3: enc = 5'h15;
        4'h4: enc = 5'h0a;
        4'h5: enc = 5'h0b;
        4'h6: enc = 5'h0e;
        4'h7: enc = 5'h0f;
        4'h8: enc = 5'h12;
        4'h9: enc = 5'h13;
        4'ha: enc = 5'h16;
        4'hb: enc = 5'h17;
        4'hc: enc = 5'h1a;
        4'hd: enc = 5'h1b;
        4'he: enc = 5'h1c;
        default: enc = 5'h1d;
      endcase
    end
  endfunction

  assign sym_o = enc(nib_i); // RULE1

  // One comparator per data code-group
  genvar i;
  generate
    for (i = 0; i < 16; i = i + 1)
    begin : g_dec
      assign hit[i] = (grp_i == enc(i[3:0]));
    end
  endgenerate

  assign data_o = |hit;

  // Nibble of the matching entry
  integer k;
  always @*
  begin
    nib_o = 4'h0;
    for (k = 0; k < 16; k = k + 1)
      if (hit[k])
        nib_o = k[3:0];
  end

endmodule

//--- fast_ethernet_tx_line_coder.v
// 100 Mbps PCS/PMA coding path: 4B/5B, scrambling, NRZI, MLT-3 and receive
`timescale 1ns/1ps
`include "fe_line_coder_defines.vh"
module fast_ethernet_tx_line_coder #(
  parameter [14:0] UNLOCK_CYC = `UNLOCK_US * `CLK_MHZ
) (
  // Clock and reset
  input  wire       clk_i,
  input  wire       rst_i,
  // MAC transmit nibbles
  input  wire       tx_valid_i,
  output wire       tx_ready_o,
  input  wire       tx_en_i,
  input  wire       tx_er_i,
  input  wire [3:0] txd_i,
  // Configuration
  input  wire       scr_bypass_i,
  // Line transmit
  output reg        nrzi_o,
  output reg        mlt_pos_o,
  output reg        mlt_neg_o,
  // Line receive, recovered NRZI bit
  input  wire       rx_nrzi_i,
  // MII receive
  output reg  [3:0] rxd_o,
  output reg        rx_dv_o,
  output reg        rx_er_o,
  output reg        rx_strobe_o,
  // RMII receive
  output reg  [1:0] rmii_rxd_o,
  output reg        rmii_strobe_o,
  // Status
  output reg        link_up_o,
  output reg        bad_ssd_o
);

  // Transmit states, group to send at the next boundary
  localparam [3:0] T_IDLE = 4'h1;
  localparam [3:0] T_K    = 4'h2;
  localparam [3:0] T_DATA = 4'h4;
  localparam [3:0] T_END  = 4'h8;

  // Receive states
  localparam [4:0] R_IDLE = 5'h01;
  localparam [4:0] R_DATA = 5'h02;
  localparam [4:0] R_END  = 5'h04;
  localparam [4:0] R_LPI  = 5'h08;
  localparam [4:0] R_BAD  = 5'h10;

  // Transmit signals
  wire        b_valid;
  wire [5:0]  b_data;
  wire        b_en;
  wire        b_er;
  wire [3:0]  b_nib;
  wire [4:0]  enc_sym;
  reg  [3:0]  tstate;
  reg  [3:0]  next_tstate;
  reg  [4:0]  next_sym;
  reg         take;
  reg  [4:0]  tsh;
  reg  [2:0]  bcnt;
  reg  [10:0] sl;
  reg  [1:0]  phase;
  wire        load;
  wire        skey;
  wire        tbit;
  wire [1:0]  next_phase;

  // Receive signals
  reg         s1;
  reg         s2;
  reg         prev;
  wire        nrz;
  reg  [10:0] dl;
  wire        dkey;
  wire        d;
  reg  [6:0]  ones;
  reg         locked;
  reg  [14:0] tmo;
  reg  [9:0]  sh;
  reg  [3:0]  ssd_cnt;
  reg  [2:0]  gcnt;
  reg  [4:0]  rstate;
  reg  [1:0]  rm_cnt;
  wire [3:0]  dec_nib;
  wire        dec_data;
  wire        grp_done;
  wire [4:0]  grp;

  // Nibble buffer absorbs the five-clock group pace
  nibble_buf u_buf (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (tx_valid_i),
    .in_ready_o  (tx_ready_o),
    .in_data_i   ({tx_en_i, tx_er_i, txd_i}),
    .out_valid_o (b_valid),
    .out_ready_i (take),
    .out_data_o  (b_data)
  );

  assign b_en  = b_data[5];
  assign b_er  = b_data[4];
  assign b_nib = b_data[3:0];

  // Shared code table, encode and decode halves
  code_5b u_code (
    .nib_i  (b_nib),
    .sym_o  (enc_sym),
    .grp_i  (grp),
    .nib_o  (dec_nib),
    .data_o (dec_data)
  );

  // A new code-group is chosen every fifth clock
  assign load = (bcnt == 3'h4); // RULE13

  // Transmit sequencing at each group boundary
  always @*
  begin
    next_tstate = tstate;
    next_sym    = `SYM_I;
    take        = 1'b0;
    case (tstate)
      T_IDLE:
      begin
        if (load && b_valid)
        begin
          take = 1'b1;
          if (b_en)
          begin
            next_sym    = `SYM_J; // RULE2
            next_tstate = T_K;
          end
          else if (b_er && b_nib == `LPI_NIB)
            next_sym = `SYM_P; // RULE7
          else
            next_sym = `SYM_I; // RULE5
        end
      end
      T_K:
      begin
        next_sym = `SYM_K; // RULE2
        if (load)
        begin
          take        = b_valid;
          next_tstate = T_DATA;
        end
      end
      T_DATA:
      begin
        if (b_valid && b_en)
        begin
          take     = load;
          next_sym = b_er ? `SYM_H : enc_sym; // RULE3 RULE19
        end
        else if (b_valid)
        begin
          next_sym = `SYM_T; // RULE4
          if (load)
            next_tstate = T_END;
        end
        else
          next_sym = `SYM_H; // RULE6
      end
      T_END:
      begin
        next_sym = `SYM_R; // RULE4
        if (load)
          next_tstate = T_IDLE; // RULE16
      end
      default:
      begin
        next_tstate = T_IDLE;
      end
    endcase
  end

  // Scrambler key and line bit
  assign skey = sl[10] ^ sl[8]; // RULE17
  assign tbit = scr_bypass_i ? tsh[4] : (tsh[4] ^ skey); // RULE9 RULE10
  assign next_phase = phase + {1'b0, tbit}; // RULE18

  // Serializer, scrambler, NRZI and MLT-3 phase
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tstate    <= T_IDLE;
      tsh       <= `SYM_I;
      bcnt      <= 3'h0;
      sl        <= `LFSR_INIT;
      nrzi_o    <= 1'b0;
      phase     <= 2'h0;
      mlt_pos_o <= 1'b0;
      mlt_neg_o <= 1'b0;
    end
    else
    begin
      if (load)
      begin
        tstate <= next_tstate;
        tsh    <= next_sym;
        bcnt   <= 3'h0;
      end
      else
      begin
        tsh  <= {tsh[3:0], 1'b0};
        bcnt <= bcnt + 3'h1;
      end
      if (sl == 11'h000)
        sl <= `LFSR_INIT; // RULE17
      else
        sl <= {sl[9:0], skey}; // RULE9
      nrzi_o    <= nrzi_o ^ tbit; // RULE11 RULE18
      phase     <= next_phase;
      mlt_pos_o <= (next_phase == 2'h1); // RULE12
      mlt_neg_o <= (next_phase == 2'h3); // RULE12
    end
  end

  // Receive bit: NRZI back to NRZ, then descramble
  assign nrz  = s2 ^ prev;
  assign dkey = dl[10] ^ dl[8];
  assign d    = nrz ^ dkey; // RULE15
  assign grp  = sh[4:0];
  assign grp_done = (gcnt == 3'h5);

  // Pin synchroniser, descrambler lock and link monitor
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1        <= 1'b0;
      s2        <= 1'b0;
      prev      <= 1'b0;
      dl        <= 11'h000;
      ones      <= 7'h00;
      locked    <= 1'b0;
      tmo       <= 15'h0000;
      link_up_o <= 1'b0;
    end
    else
    begin
      s1   <= rx_nrzi_i;
      s2   <= s1;
      prev <= s2;
      if (locked)
        dl <= {dl[9:0], dkey};
      else
        dl <= {dl[9:0], ~nrz}; // RULE17
      if (!d)
        ones <= 7'h00;
      else if (ones != `LOCK_ONES)
        ones <= ones + 7'h01;
      if (!locked)
      begin
        tmo <= 15'h0000;
        if (ones == `LOCK_ONES)
          locked <= 1'b1; // RULE17
      end
      else if (rstate == R_IDLE && sh[4:0] == `SYM_I)
        tmo <= 15'h0000;
      else if (tmo == UNLOCK_CYC - 15'h0001)
        locked <= 1'b0; // RULE15
      else
        tmo <= tmo + 15'h0001;
      link_up_o <= locked; // RULE15
    end
  end

  // Alignment, 5B/4B decode and error reporting
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sh          <= 10'h3ff;
      ssd_cnt     <= 4'h0;
      gcnt        <= 3'h0;
      rstate      <= R_IDLE;
      rxd_o       <= 4'h0;
      rx_dv_o     <= 1'b0;
      rx_er_o     <= 1'b0;
      rx_strobe_o <= 1'b0;
      bad_ssd_o   <= 1'b0;
    end
    else
    begin
      sh          <= {sh[8:0], d}; // RULE15
      rx_strobe_o <= 1'b0;
      bad_ssd_o   <= 1'b0;
      gcnt        <= grp_done ? 3'h1 : gcnt + 3'h1;
      if (!locked)
      begin
        rstate  <= R_IDLE;
        ssd_cnt <= 4'h0;
        rx_dv_o <= 1'b0;
        rx_er_o <= 1'b0;
      end
      else
      case (rstate)
        R_IDLE:
        begin
          rx_er_o <= 1'b0;
          if (ssd_cnt == 4'h8)
          begin
            ssd_cnt <= 4'h0;
            if (sh == `SSD_PAIR)
            begin
              rstate <= R_DATA; // RULE15
              gcnt   <= 3'h1;
            end
            else if (sh[7:0] == 8'h00)
            begin
              rstate  <= R_LPI; // RULE7
              rxd_o   <= `LPI_NIB;
              rx_er_o <= 1'b1;
            end
            else
            begin
              rstate    <= R_BAD;
              bad_ssd_o <= 1'b1; // RULE15
            end
          end
          else if (ssd_cnt != 4'h0 || !d)
            ssd_cnt <= ssd_cnt + 4'h1;
        end
        R_DATA:
        begin
          if (grp_done)
          begin
            rx_strobe_o <= 1'b1;
            if (dec_data)
            begin
              rxd_o   <= dec_nib; // RULE14
              rx_dv_o <= 1'b1;
              rx_er_o <= 1'b0;
            end
            else if (grp == `SYM_T)
            begin
              rstate      <= R_END;
              rx_strobe_o <= 1'b0;
            end
            else
            begin
              rx_er_o <= 1'b1; // RULE8
              if (grp == `SYM_I)
              begin
                rstate  <= R_IDLE;
                rx_dv_o <= 1'b0;
              end
            end
          end
        end
        R_END:
        begin
          if (grp_done)
          begin
            rstate  <= R_IDLE;
            rx_dv_o <= 1'b0;
            rx_er_o <= (grp != `SYM_R);
          end
        end
        R_LPI:
        begin
          if (sh[4:0] == `SYM_I)
          begin
            rstate  <= R_IDLE;
            rx_er_o <= 1'b0;
          end
        end
        R_BAD:
        begin
          if (sh == 10'h3ff)
            rstate <= R_IDLE;
        end
        default:
        begin
          rstate <= R_IDLE;
        end
      endcase
    end
  end

  // RMII dibits, low pair first, after each nibble strobe
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rm_cnt        <= 2'h0;
      rmii_rxd_o    <= 2'h0;
      rmii_strobe_o <= 1'b0;
    end
    else
    begin
      rmii_strobe_o <= 1'b0;
      if (rx_strobe_o)
      begin
        rmii_rxd_o    <= rxd_o[1:0]; // RULE14
        rmii_strobe_o <= 1'b1;
        rm_cnt        <= 2'h1;
      end
      else if (rm_cnt == 2'h1)
      begin
        rmii_rxd_o    <= rxd_o[3:2];
        rmii_strobe_o <= 1'b1;
        rm_cnt        <= 2'h0;
      end
    end
  end

endmodule

//--- fe_line_coder_defines.vh
// Constants for the 100 Mbps line coder: code-groups, seeds and timing
//Summary of operation
// (RULE1) Each data nibble maps to its fixed 5-bit code-group from the table.
// (RULE2) A frame start replaces two preamble nibbles by code-groups 11000, 10001.
// (RULE3) Remaining preamble and data nibbles are each coded to their group.
// (RULE4) When transmit enable falls, send 01101 then 00111.
// (RULE5) After the end pair, send idle 11111 until transmit enable returns.
// (RULE6) Code-group 00100 is the halt group that marks an error.
// (RULE7) Low-power idle: enable low, error high, nibble 0001, group 00000.
// (RULE8) Idle, start, end or undefined groups inside a frame raise receive error.
// (RULE9) An 11-bit closed-loop LFSR is XORed with each serial encoder bit.
// (RULE10) A bypass input passes encoded bits through unscrambled.
// (RULE11) NRZI coding is always applied before the driver, never bypassed.
// (RULE12) Two drive streams carry alternate one events, giving MLT-3.
// (RULE13) Transmit accepts 4-bit nibbles and sends five line bits per nibble.
// (RULE14) Receive gives 4-bit nibbles and 2-bit RMII words.
// (RULE15) Receive descrambles, aligns, decodes, checks link and bad start.
// (RULE16) Transmit follows the idle, start, data, end, error sequence; the code goes from end back to idle and has no error state.
// (RULE17) Scrambler uses x^11+x^9+1, never all zero; descrambler locks on idle.
// (RULE18) NRZI toggles on each one; MLT-3 steps +1,0,-1,0 on each one.
// (RULE19) Error with enable during a frame sends the halt group.
`ifndef FE_LINE_CODER_DEFINES_VH
`define FE_LINE_CODER_DEFINES_VH

// Control code-groups, first transmitted bit in bit 4
`define SYM_I      5'h1f
`define SYM_J      5'h18
`define SYM_K      5'h11
`define SYM_T      5'h0d
`define SYM_R      5'h07
`define SYM_H      5'h04
`define SYM_P      5'h00
`define SSD_PAIR   10'h311
`define LPI_NIB    4'h1

// Scrambler seed, any non-zero value
`define LFSR_INIT  11'h7ff

// Consecutive idle bits needed to declare descrambler lock
`define LOCK_ONES  7'h3c

// Clock rate and loss-of-lock time
`define CLK_MHZ    20
`define UNLOCK_US  722

`endif

//--- line_coder_sva.sv
// Port-level assertions for the 100 Mbps line coder
`timescale 1ns/1ps
module line_coder_sva #(
  parameter [14:0] UNLOCK_CYC = 15'd200
) (
  // Clock and reset
  input wire       clk_i,
  input wire       rst_i,
  // Watched outputs
  input wire       tx_ready_o,
  input wire       nrzi_o,
  input wire       mlt_pos_o,
  input wire       mlt_neg_o,
  input wire [3:0] rxd_o,
  input wire       rx_dv_o,
  input wire       rx_strobe_o,
  input wire [1:0] rmii_rxd_o,
  input wire       rmii_strobe_o,
  input wire       link_up_o,
  input wire       bad_ssd_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  reg last_neg;
  // Polarity of the last nonzero drive level
  always @(posedge clk_i)
    if (rst_i)
      last_neg <= 1'b1;
    else if (mlt_pos_o | mlt_neg_o)
      last_neg <= mlt_neg_o;
  // Low then high dibit after each nibble
  sequence s_lo;
    rmii_strobe_o && rmii_rxd_o == rxd_o[1:0];
  endsequence
  sequence s_hi;
    rmii_strobe_o && rmii_rxd_o == rxd_o[3:2];
  endsequence
  property p_rmii;
    rx_strobe_o && rx_dv_o |=> s_lo ##1 s_hi;
  endproperty
  a_rmii: assert property (p_rmii)
    else $error("rmii dibits wrong");
  property p_excl;
    !(mlt_pos_o && mlt_neg_o);
  endproperty
  a_excl: assert property (p_excl)
    else $error("both drive phases high");
  property p_hold;
    !$changed(nrzi_o) |-> $stable(mlt_pos_o) && $stable(mlt_neg_o);
  endproperty
  a_hold: assert property (p_hold)
    else $error("mlt moved without a one");
  property p_step;
    $changed(nrzi_o) |->
      (mlt_pos_o | mlt_neg_o) != ($past(mlt_pos_o) | $past(mlt_neg_o));
  endproperty
  a_step: assert property (p_step)
    else $error("mlt did not step on a one");
  property p_alt;
    $rose(mlt_pos_o) || $rose(mlt_neg_o) |-> last_neg == mlt_pos_o;
  endproperty
  a_alt: assert property (p_alt)
    else $error("mlt polarity did not alternate");
  property p_gap;
    rx_strobe_o |=> !rx_strobe_o [*4];
  endproperty
  a_gap: assert property (p_gap)
    else $error("receive strobes closer than a group");
  property p_quiet;
    !link_up_o && !$past(link_up_o) |-> !rx_dv_o && !rx_strobe_o;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("receive output while unlocked");
  property p_ssd;
    bad_ssd_o |=> !bad_ssd_o;
  endproperty
  a_ssd: assert property (p_ssd)
    else $error("bad start flag longer than a pulse");
  property p_rst;
    $fell(rst_i) |-> tx_ready_o && !link_up_o && !rx_dv_o;
  endproperty
  a_rst: assert property (p_rst)
    else $error("wrong state after reset");
  property p_ready;
    $fell(tx_ready_o) |-> ##[1:15] tx_ready_o;
  endproperty
  a_ready: assert property (p_ready)
    else $error("buffer not drained within three groups");
endmodule

bind fast_ethernet_tx_line_coder line_coder_sva #(.UNLOCK_CYC(UNLOCK_CYC))
  chk_u (.clk_i(clk_i), .rst_i(rst_i), .tx_ready_o(tx_ready_o),
  .nrzi_o(nrzi_o), .mlt_pos_o(mlt_pos_o), .mlt_neg_o(mlt_neg_o),
  .rxd_o(rxd_o), .rx_dv_o(rx_dv_o), .rx_strobe_o(rx_strobe_o),
  .rmii_rxd_o(rmii_rxd_o), .rmii_strobe_o(rmii_strobe_o),
  .link_up_o(link_up_o), .bad_ssd_o(bad_ssd_o));

//--- mac_model.sv
// MAC model that offers transmit nibbles from a queue
`timescale 1ns/1ps
module mac_model (
  // Clock and reset
  input  wire       clk_i,
  input  wire       rst_i,
  // Nibble handshake
  input  wire       ready_i,
  output reg        valid_o,
  output reg        en_o,
  output reg        er_o,
  output reg  [3:0] txd_o
);
  logic [5:0] q[$];
  // Queues a nibble with its enable and error bits
  task push(input logic [5:0] v);
    q.push_back(v);
  endtask
  initial {valid_o, en_o, er_o, txd_o} = 7'h00;
  // Holds a nibble until taken; lines wander while idle
  always @(posedge clk_i)
  begin
    if (!rst_i && valid_o && ready_i)
      void'(q.pop_front());
    #1;
    valid_o = q.size() > 0;
    if (valid_o)
      {en_o, er_o, txd_o} = q[0];
    else
      {en_o, er_o, txd_o} = ~{en_o, er_o, txd_o};
  end
endmodule

//--- nibble_buf.v
// Two-entry buffer for transmit nibbles with valid and ready on each side
`timescale 1ns/1ps
module nibble_buf (
  // Clock and reset
  input  wire       clk_i,
  input  wire       rst_i,
  // Filling side
  input  wire       in_valid_i,
  output wire       in_ready_o,
  input  wire [5:0] in_data_i,
  // Draining side
  output wire       out_valid_o,
  input  wire       out_ready_i,
  output wire [5:0] out_data_o
);

  reg  [5:0] mem [0:1];
  reg        wptr;
  reg        rptr;
  reg  [1:0] cnt;
  wire       push;
  wire       pop;

  // Handshakes and head entry
  assign in_ready_o  = (cnt != 2'h2);
  assign out_valid_o = (cnt != 2'h0);
  assign out_data_o  = mem[rptr];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // Storage and pointers
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wptr <= 1'b0;
      rptr <= 1'b0;
      cnt  <= 2'h0;
    end
    else
    begin
      if (push)
      begin
        mem[wptr] <= in_data_i;
        wptr      <= ~wptr;
      end
      if (pop)
        rptr <= ~rptr;
      cnt <= cnt + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule

//--- tb_top.sv
// Testbench: MAC model feeds the coder, line loops back to receive
`timescale 1ns/1ps
module tb_top;
  localparam logic [4:0] ENC [16] = '{5'h1e, 5'h09, 5'h14, 5'h15,
    5'h0a, 5'h0b, 5'h0e, 5'h0f, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1a,
    5'h1b, 5'h1c, 5'h1d};
  reg         clk_i = 1'b0;
  reg         rst_i = 1'b1;
  reg         scr_bypass_i = 1'b0;
  wire        tx_valid_i, tx_ready_o, tx_en_i, tx_er_i, nrzi_o;
  wire        mlt_pos_o, mlt_neg_o, rx_dv_o, rx_er_o, rx_strobe_o;
  wire        rmii_strobe_o, link_up_o, bad_ssd_o;
  wire [3:0]  txd_i, rxd_o;
  wire [1:0]  rmii_rxd_o;
  logic [4:0] grp_q[$], nib_q[$], e;
  logic [9:0] sh = 10'h000;
  logic       prev = 1'b0, b, hunt = 1'b1, rx_chk = 1'b0, lpi_rx = 1'b0;
  integer     failures = 0, compares = 0, seed = 15988, cyc = 0;
  integer     bn = 0, zrun = 0, zmax = 0;
  always #25 clk_i = ~clk_i;
  fast_ethernet_tx_line_coder #(.UNLOCK_CYC(15'd200)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .tx_valid_i(tx_valid_i),
    .tx_ready_o(tx_ready_o), .tx_en_i(tx_en_i), .tx_er_i(tx_er_i),
    .txd_i(txd_i), .scr_bypass_i(scr_bypass_i), .nrzi_o(nrzi_o),
    .mlt_pos_o(mlt_pos_o), .mlt_neg_o(mlt_neg_o), .rx_nrzi_i(nrzi_o),
    .rxd_o(rxd_o), .rx_dv_o(rx_dv_o), .rx_er_o(rx_er_o),
    .rx_strobe_o(rx_strobe_o), .rmii_rxd_o(rmii_rxd_o),
    .rmii_strobe_o(rmii_strobe_o), .link_up_o(link_up_o),
    .bad_ssd_o(bad_ssd_o));
  mac_model mac_u (.clk_i(clk_i), .rst_i(rst_i), .ready_i(tx_ready_o),
    .valid_o(tx_valid_i), .en_o(tx_en_i), .er_o(tx_er_i), .txd_o(txd_i));
  task chk(input logic [4:0] got, input logic [4:0] exp, input string m);
    compares = compares + 1;
    if (got !== exp)
    begin
      failures = failures + 1;
      $display("ERROR %0t %s: got %h want %h", $time, m, got, exp);
    end
  endtask
  task conclude;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task cycles(input integer n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // Queues a nibble and notes the group or nibble that must follow
  task put(input logic en, input logic er, input logic [3:0] n,
           input logic [4:0] g);
    mac_u.push({en, er, n});
    if (scr_bypass_i)
      grp_q.push_back(g);
    else if (en && g != 5'h18 && g != 5'h11)
      nib_q.push_back({er, er ? 4'h0 : n});
  endtask
  // Frame of n nibbles, two preamble first; nibble h carries an error
  task frame(input integer n, input integer h, input logic rnd);
    logic [3:0] d;
    for (int i = 0; i < n; i++)
    begin
      d = i < 2 ? 4'h5 : rnd ? 4'($random(seed)) : 4'(i - 2);
      put(1'b1, i == h, d, i == 0 ? 5'h18 : i == 1 ? 5'h11 :
          i == h ? 5'h04 : ENC[d]);
    end
    put(1'b0, 1'b0, 4'h0, 5'h0d);
    if (scr_bypass_i)
      grp_q.push_back(5'h07);
  endtask
  task drain(input string t);
    integer k;
    for (k = 0; k < 3000 && grp_q.size() + nib_q.size() > 0; k++)
      @(posedge clk_i);
    cycles(40);
    chk({4'h0, k < 3000}, 5'h01, "drain");
    $display("test %s done", t);
  endtask
  task relock;
    integer k;
    for (k = 0; k < 600 && link_up_o !== 1'b1; k++)
      @(posedge clk_i);
    #1;
    chk({4'h0, link_up_o}, 5'h01, "lock");
    rx_chk = 1'b1;
  endtask
  // Rebuilds code-groups from the line while scrambling is off
  always @(posedge clk_i)
  begin
    b = nrzi_o ^ prev;
    prev = nrzi_o;
    sh = {sh[8:0], b};
    zrun = b ? 0 : zrun + 1;
    zmax = zrun > zmax ? zrun : zmax;
    bn = bn + 1;
    if (rst_i || !scr_bypass_i)
    begin
      hunt = 1'b1;
      sh = 10'h000;
    end
    else if (hunt && sh == 10'h311)
    begin
      hunt = 1'b0;
      bn = 0;
      chk(sh[9:5], grp_q.pop_front(), "start j");
      chk(sh[4:0], grp_q.pop_front(), "start k");
    end
    else if (!hunt && bn == 5)
    begin
      bn = 0;
      hunt = sh[4:0] == 5'h07;
      chk(sh[4:0], grp_q.pop_front(), "group");
    end
  end
  // Compares each received nibble with the oldest note
  always @(posedge clk_i)
    if (rx_chk && rx_strobe_o && (rx_dv_o || rx_er_o))
    begin
      e = nib_q.pop_front();
      if (e[4])
        chk({4'h0, rx_er_o}, 5'h01, "rx error");
      else
        chk({rx_er_o, rxd_o}, e, "rx nibble");
    end
  // Notes a low-power report on the receive outputs
  always @(posedge clk_i)
    if (rx_er_o === 1'b1 && rx_dv_o === 1'b0 && rxd_o === 4'h1)
      lpi_rx = 1'b1;
  // Cuts a hung run short
  always @(posedge clk_i)
  begin
    cyc = cyc + 1;
    if (cyc == 10000)
    begin
      failures = failures + 1;
      conclude;
    end
  end
  initial
  begin
    cycles(4);
    rst_i = 1'b0;
    relock;
    for (int f = 0; f < 3; f++)
      frame(6 + ($random(seed) & 15), f == 1 ? 5 : -1, 1'b1);
    drain("scrambled frames");
    rx_chk = 1'b0;
    scr_bypass_i = 1'b1;
    cycles(20);
    frame(18, -1, 1'b0);
    frame(6, 3, 1'b1);
    drain("bypassed frames");
    zmax = 0;
    repeat (3) mac_u.push(6'h11);
    cycles(60);
    chk({4'h0, zmax >= 15}, 5'h01, "lpi zeros");
    $display("test low power idle done");
    rst_i = 1'b1;
    scr_bypass_i = 1'b0;
    cycles(2);
    rst_i = 1'b0;
    relock;
    frame(8, -1, 1'b1);
    drain("after reset");
    lpi_rx = 1'b0;
    repeat (3) mac_u.push(6'h11);
    cycles(40);
    chk({4'h0, lpi_rx}, 5'h01, "lpi receive");
    $display("test low power receive done");
    conclude;
  end
endmodule
